// ===== hdl/usbpc_ctrl_regs.sv
// Control and status register bank of the USB peripheral side.
// Assumes a synchronous 8-bit host port and event pulses from the serial engine.
`timescale 1ns/10ps

// Summary of operation
// - Bit 6 puts the transceiver in low power.
// - Standby with transfers off means suspend.
// - Bit 5: 0 full speed, 1 low speed.
// - Bits 4:3 force normal, SE0, K or J.
// - Line-force bits clear at reset.
// - Bit 2: DMA out of device at 1, in at 0.
// - DMA enabled: count high write starts DMA.
// - Bit 0 enables transfers, clear at reset.
// - Mask bit 1 lets its event raise the request.
// - Mask writes leave the flags alone.
// - Mask bits 6:4 gate bus reset, frame start, DMA done.
// - Mask bits 3 to 0 gate endpoint 3 to 0 done.
// - Mask bit 7 reads 1 while DMA runs.
// - Device address is 00h after reset.
// - Only tokens to the device address are answered.
// - Decode at 05h-07h, 0Dh-0Fh, 15h-16h, 35h-36h.
// - Flag write 1 clears, 0 keeps; reads show flags.
module usbpc_ctrl_regs (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic a0_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    input usbpc_pkg::usbpc_events_t events_i,
    input wire logic [10:0] frame_number_i,
    input wire logic [3:0] buffer_set_i,
    input wire logic token_valid_i,
    input wire logic [6:0] token_addr_i,
    input wire logic dma_byte_i,
    output logic transceiver_standby_o,
    output logic suspend_o,
    output logic speed_select_o,
    output usbpc_pkg::usbpc_line_drive_t line_drive_o,
    output logic dma_dir_o,
    output logic dma_enable_o,
    output logic usb_enable_o,
    output logic master_mode_o,
    output logic polarity_swap_o,
    output logic dma_start_o,
    output logic dma_busy_o,
    output logic addr_match_o,
    output logic interrupt_request_out_o
);

    // ****************************************
    // Declarations
    // ****************************************
    usbpc_pkg::usbpc_access_t acc;
    usbpc_pkg::usbpc_dma_state_t dma_state_q;
    usbpc_pkg::usbpc_line_force_t line_force;
    logic [7:0] ctrl_one_q;
    logic [7:0] int_mask_q;
    logic [7:0] dev_addr_q;
    logic [7:0] ctrl_two_q;
    logic [7:0] frame_lo_q;
    logic [7:0] frame_hi_q;
    logic [7:0] dma_cnt_lo_q;
    logic [7:0] dma_cnt_hi_q;
    logic [15:0] dma_remain_q;
    logic [15:0] dma_total;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic dma_start_q;
    logic dma_done_pulse;
    logic dma_kick;
    logic standby_q;
    logic suspend_q;
    logic addr_match_q;
    logic [usbpc_pkg::NUM_EVENTS-1:0] flag_set;
    logic [usbpc_pkg::NUM_EVENTS-1:0] flag_clr;
    logic [usbpc_pkg::NUM_EVENTS-1:0] flags;
    logic irq;

    // ****************************************
    // Host port
    // ****************************************
    usbpc_host_port u_port (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .cs_n_i(cs_n_i),
        .rd_n_i(rd_n_i),
        .wr_n_i(wr_n_i),
        .a0_i(a0_i),
        .data_i(data_i),
        .acc_o(acc)
    );

    // ****************************************
    // First control register
    // ****************************************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_one_q <= usbpc_pkg::CTRL_ONE_RST;
        end else if (usbpc_pkg::wr_hit(acc, usbpc_pkg::OFS_CTRL_ONE)) begin
            ctrl_one_q <= usbpc_pkg::upd(ctrl_one_q, acc.wdata, usbpc_pkg::CTRL_ONE_WMASK);
        end
    end

    assign line_force = usbpc_pkg::usbpc_line_force_t'(
        {ctrl_one_q[usbpc_pkg::CTRL1_FORCE_HI_BIT], ctrl_one_q[usbpc_pkg::CTRL1_FORCE_LO_BIT]});

    // Standby, suspend and forced line states
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            standby_q <= 1'b0;
            suspend_q <= 1'b0;
        end else begin
            standby_q <= ctrl_one_q[usbpc_pkg::CTRL1_STANDBY_BIT];
            suspend_q <= ctrl_one_q[usbpc_pkg::CTRL1_STANDBY_BIT]
                && !ctrl_one_q[usbpc_pkg::CTRL1_USB_EN_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            line_drive_o <= '0;
        end else begin
            unique case (line_force)
                usbpc_pkg::LINE_NORMAL: begin
                    line_drive_o <= '0;
                end
                usbpc_pkg::LINE_SE0: begin
                    line_drive_o <= '{force_en: 1'b1, dp: 1'b0, dm: 1'b0};
                end
                usbpc_pkg::LINE_K: begin
                    line_drive_o <= '{force_en: 1'b1, dp: 1'b0, dm: 1'b1};
                end
                usbpc_pkg::LINE_J: begin
                    line_drive_o <= '{force_en: 1'b1, dp: 1'b1, dm: 1'b0};
                end
            endcase
        end
    end

    assign transceiver_standby_o = standby_q;
    assign suspend_o = suspend_q;
    assign speed_select_o = ctrl_one_q[usbpc_pkg::CTRL1_SPEED_BIT];
    assign dma_dir_o = ctrl_one_q[usbpc_pkg::CTRL1_DMA_DIR_BIT];
    assign dma_enable_o = ctrl_one_q[usbpc_pkg::CTRL1_DMA_EN_BIT];
    assign usb_enable_o = ctrl_one_q[usbpc_pkg::CTRL1_USB_EN_BIT];

    // ****************************************
    // Interrupt mask register
    // ****************************************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            int_mask_q <= usbpc_pkg::INT_MASK_RST;
        end else if (usbpc_pkg::wr_hit(acc, usbpc_pkg::OFS_INT_MASK)) begin
            int_mask_q <= usbpc_pkg::upd(int_mask_q, acc.wdata, usbpc_pkg::INT_MASK_WMASK);
        end
    end

    // ****************************************
    // Device address and token match
    // ****************************************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dev_addr_q <= usbpc_pkg::DEV_ADDR_RST;
        end else if (usbpc_pkg::wr_hit(acc, usbpc_pkg::OFS_DEV_ADDR)) begin
            dev_addr_q <= acc.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            addr_match_q <= 1'b0;
        end else begin
            addr_match_q <= token_valid_i && usb_enable_o
                && ({1'b0, token_addr_i} == dev_addr_q);
        end
    end

    assign addr_match_o = addr_match_q;

    // ****************************************
    // Second control register
    // ****************************************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_two_q <= usbpc_pkg::CTRL_TWO_RST;
        end else if (usbpc_pkg::wr_hit(acc, usbpc_pkg::OFS_CTRL_TWO)) begin
            ctrl_two_q <= usbpc_pkg::upd(ctrl_two_q, acc.wdata, usbpc_pkg::CTRL_TWO_WMASK);
        end
    end

    assign master_mode_o = ctrl_two_q[usbpc_pkg::CTRL2_MASTER_BIT];
    assign polarity_swap_o = ctrl_two_q[usbpc_pkg::CTRL2_POLARITY_BIT];

    // ****************************************
    // Frame number capture
    // ****************************************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            frame_lo_q <= 8'h00;
            frame_hi_q <= 8'h00;
        end else if (events_i.sof) begin
            frame_lo_q <= {frame_number_i[6:0], 1'b0};
            frame_hi_q <= {frame_number_i[10:7], 4'h0};
        end
    end

    // ****************************************
    // DMA count and progress
    // ****************************************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dma_cnt_lo_q <= usbpc_pkg::DMA_CNT_RST;
            dma_cnt_hi_q <= usbpc_pkg::DMA_CNT_RST;
        end else begin
            if (usbpc_pkg::wr_hit(acc, usbpc_pkg::OFS_DMA_CNT_LO)) begin
                dma_cnt_lo_q <= acc.wdata;
            end
            if (usbpc_pkg::wr_hit(acc, usbpc_pkg::OFS_DMA_CNT_HI)) begin
                dma_cnt_hi_q <= acc.wdata;
            end
        end
    end

    assign dma_total = {acc.wdata, dma_cnt_lo_q};
    assign dma_kick = usbpc_pkg::wr_hit(acc, usbpc_pkg::OFS_DMA_CNT_HI)
        && ctrl_one_q[usbpc_pkg::CTRL1_DMA_EN_BIT];

    // Remaining bytes, zero count finishes at once
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dma_state_q <= usbpc_pkg::DMA_IDLE;
            dma_remain_q <= usbpc_pkg::DMA_REMAIN_RST;
            dma_start_q <= 1'b0;
        end else begin
            dma_start_q <= dma_kick && (dma_state_q == usbpc_pkg::DMA_IDLE);
            unique case (dma_state_q)
                usbpc_pkg::DMA_IDLE: begin
                    if (dma_kick && (dma_total != 16'h0000)) begin
                        dma_state_q <= usbpc_pkg::DMA_RUN;
                        dma_remain_q <= dma_total;
                    end
                end
                usbpc_pkg::DMA_RUN: begin
                    if (!ctrl_one_q[usbpc_pkg::CTRL1_DMA_EN_BIT]) begin
                        dma_state_q <= usbpc_pkg::DMA_IDLE;
                        dma_remain_q <= usbpc_pkg::DMA_REMAIN_RST;
                    end else if (dma_byte_i) begin
                        dma_remain_q <= dma_remain_q - 16'h0001;
                        if (dma_remain_q == 16'h0001) begin
                            dma_state_q <= usbpc_pkg::DMA_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign dma_done_pulse =
        ((dma_state_q == usbpc_pkg::DMA_IDLE) && dma_kick && (dma_total == 16'h0000))
        || ((dma_state_q == usbpc_pkg::DMA_RUN) && ctrl_one_q[usbpc_pkg::CTRL1_DMA_EN_BIT]
            && dma_byte_i && (dma_remain_q == 16'h0001));

    assign dma_start_o = dma_start_q;
    assign dma_busy_o = (dma_state_q == usbpc_pkg::DMA_RUN);

    // ****************************************
    // Event flags and request output
    // ****************************************
    assign flag_set = {events_i.usb_reset, events_i.sof, dma_done_pulse,
        events_i.ep_done};
    assign flag_clr = usbpc_pkg::wr_hit(acc, usbpc_pkg::OFS_INT_FLAGS)
        ? acc.wdata[usbpc_pkg::NUM_EVENTS-1:0] : '0;

    usbpc_event_flags u_flags (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .set_i(flag_set),
        .clr_i(flag_clr),
        .mask_i(int_mask_q[usbpc_pkg::NUM_EVENTS-1:0]),
        .flags_o(flags),
        .irq_o(irq)
    );

    assign interrupt_request_out_o = irq;

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        unique case (acc.addr)
            usbpc_pkg::OFS_CTRL_ONE: rdata_d = ctrl_one_q;
            usbpc_pkg::OFS_INT_MASK: rdata_d = {dma_busy_o,
                int_mask_q[usbpc_pkg::NUM_EVENTS-1:0]};
            usbpc_pkg::OFS_DEV_ADDR: rdata_d = dev_addr_q;
            usbpc_pkg::OFS_INT_FLAGS: rdata_d = {dma_busy_o, flags};
            usbpc_pkg::OFS_BUF_SET: rdata_d = {4'h0, buffer_set_i};
            usbpc_pkg::OFS_CTRL_TWO: rdata_d = ctrl_two_q;
            usbpc_pkg::OFS_FRAME_LO: rdata_d = frame_lo_q;
            usbpc_pkg::OFS_FRAME_HI: rdata_d = frame_hi_q;
            usbpc_pkg::OFS_DMA_CNT_LO: rdata_d = dma_cnt_lo_q;
            usbpc_pkg::OFS_DMA_CNT_HI: rdata_d = dma_cnt_hi_q;
            default: rdata_d = usbpc_pkg::READ_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= usbpc_pkg::READ_IDLE;
        end else if (acc.rd) begin
            rdata_q <= rdata_d;
        end
    end

    assign data_o = rdata_q;
    assign data_oe_o = !cs_n_i && !rd_n_i && a0_i;

endmodule : usbpc_ctrl_regs

// ===== shared/usbpc_pkg.sv
// Constants and carrier types of the USB peripheral register bank.
// Assumes an 8-bit host port with an address phase before each data phase.
package usbpc_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFS_CTRL_ONE = 8'h05;
    localparam logic [7:0] OFS_INT_MASK = 8'h06;
    localparam logic [7:0] OFS_DEV_ADDR = 8'h07;
    localparam logic [7:0] OFS_INT_FLAGS = 8'h0D;
    localparam logic [7:0] OFS_BUF_SET = 8'h0E;
    localparam logic [7:0] OFS_CTRL_TWO = 8'h0F;
    localparam logic [7:0] OFS_FRAME_LO = 8'h15;
    localparam logic [7:0] OFS_FRAME_HI = 8'h16;
    localparam logic [7:0] OFS_DMA_CNT_LO = 8'h35;
    localparam logic [7:0] OFS_DMA_CNT_HI = 8'h36;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL1_STANDBY_BIT = 6;
    localparam int CTRL1_SPEED_BIT = 5;
    localparam int CTRL1_FORCE_HI_BIT = 4;
    localparam int CTRL1_FORCE_LO_BIT = 3;
    localparam int CTRL1_DMA_DIR_BIT = 2;
    localparam int CTRL1_DMA_EN_BIT = 1;
    localparam int CTRL1_USB_EN_BIT = 0;
    localparam int MASK_DMA_BUSY_BIT = 7;
    localparam int CTRL2_MASTER_BIT = 7;
    localparam int CTRL2_POLARITY_BIT = 6;
    localparam int NUM_EVENTS = 7;

    // Writable bits of the control and mask registers
    localparam logic [7:0] CTRL_ONE_WMASK = 8'h7F;
    localparam logic [7:0] INT_MASK_WMASK = 8'h7F;
    localparam logic [7:0] CTRL_TWO_WMASK = 8'hC0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] CTRL_ONE_RST = 8'h00;
    localparam logic [7:0] INT_MASK_RST = 8'h00;
    localparam logic [7:0] DEV_ADDR_RST = 8'h00;
    localparam logic [7:0] CTRL_TWO_RST = 8'h00;
    localparam logic [7:0] DMA_CNT_RST = 8'h00;
    localparam logic [15:0] DMA_REMAIN_RST = 16'h0000;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        LINE_NORMAL,
        LINE_SE0,
        LINE_K,
        LINE_J
    } usbpc_line_force_t;

    typedef enum logic {
        DMA_IDLE,
        DMA_RUN
    } usbpc_dma_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } usbpc_access_t;

    typedef struct packed {
        logic usb_reset;
        logic sof;
        logic [3:0] ep_done;
    } usbpc_events_t;

    typedef struct packed {
        logic force_en;
        logic dp;
        logic dm;
    } usbpc_line_drive_t;

    // Register write hit
    function automatic logic wr_hit(input usbpc_access_t acc, input logic [7:0] ofs);
        wr_hit = acc.wr && (acc.addr == ofs);
    endfunction : wr_hit

    // Masked register update
    function automatic logic [7:0] upd(input logic [7:0] old, input logic [7:0] wd,
                                       input logic [7:0] wmask);
        upd = (old & ~wmask) | (wd & wmask);
    endfunction : upd

endpackage : usbpc_pkg

// ===== hdl/usbpc_host_port.sv
// Host port front end: address latch and one-cycle read/write strobes.
// Assumes strobes and data are synchronous to clk_i.
`timescale 1ns/10ps
module usbpc_host_port (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic a0_i,
    input wire logic [7:0] data_i,
    output usbpc_pkg::usbpc_access_t acc_o
);

    logic wr_n_q;
    logic rd_n_q;
    logic [7:0] addr_q;
    logic wr_start;
    logic rd_start;

    // ****************************************
    // Strobe edges
    // ****************************************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
        end else begin
            wr_n_q <= wr_n_i | cs_n_i;
            rd_n_q <= rd_n_i | cs_n_i;
        end
    end

    assign wr_start = wr_n_q && !wr_n_i && !cs_n_i;
    assign rd_start = rd_n_q && !rd_n_i && !cs_n_i;

    // ****************************************
    // Address phase
    // ****************************************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            addr_q <= 8'h00;
        end else if (wr_start && !a0_i) begin
            addr_q <= data_i;
        end
    end

    assign acc_o.wr = wr_start && a0_i;
    assign acc_o.rd = rd_start && a0_i;
    assign acc_o.addr = addr_q;
    assign acc_o.wdata = data_i;

endmodule : usbpc_host_port

// ===== hdl/usbpc_event_flags.sv
// Sticky event flags with write-one-to-clear and masked request output.
// Assumes event inputs are one-cycle pulses in the clk_i domain.
`timescale 1ns/10ps
module usbpc_event_flags (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [usbpc_pkg::NUM_EVENTS-1:0] set_i,
    input wire logic [usbpc_pkg::NUM_EVENTS-1:0] clr_i,
    input wire logic [usbpc_pkg::NUM_EVENTS-1:0] mask_i,
    output logic [usbpc_pkg::NUM_EVENTS-1:0] flags_o,
    output logic irq_o
);

    logic [usbpc_pkg::NUM_EVENTS-1:0] flags_q;

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~clr_i) | set_i;
        end
    end

    assign flags_o = flags_q;
    assign irq_o = |(flags_q & mask_i);

endmodule : usbpc_event_flags

// ===== testbench/usbpc_ctrl_regs_properties.sv
// Port checks of the USB peripheral register bank.
// Assumes a bind into the top; data_i is the resolved bus.
`timescale 1ns/10ps
module usbpc_ctrl_regs_properties (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic cs_n_i,
    input wire logic wr_n_i,
    input wire logic a0_i,
    input wire logic [7:0] data_i,
    input usbpc_pkg::usbpc_events_t events_i,
    input wire logic token_valid_i,
    input wire logic [6:0] token_addr_i,
    input wire logic transceiver_standby_o,
    input wire logic suspend_o,
    input wire logic speed_select_o,
    input usbpc_pkg::usbpc_line_drive_t line_drive_o,
    input wire logic dma_dir_o,
    input wire logic dma_enable_o,
    input wire logic usb_enable_o,
    input wire logic dma_start_o,
    input wire logic dma_busy_o,
    input wire logic addr_match_o,
    input wire logic interrupt_request_out_o
);
    // ****************************************
    // Shadow of host writes
    // ****************************************
    logic idle_q;
    logic [7:0] addr_q, ctrl_q, mask_q, dev_q;
    logic take;
    assign take = !cs_n_i && !wr_n_i && idle_q;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            idle_q <= 1'b1;
            {addr_q, ctrl_q, mask_q, dev_q} <= '0;
        end else begin
            idle_q <= cs_n_i || wr_n_i;
            if (take && !a0_i) addr_q <= data_i;
            if (take && a0_i && addr_q == usbpc_pkg::OFS_CTRL_ONE) ctrl_q <= data_i & 8'h7F;
            if (take && a0_i && addr_q == usbpc_pkg::OFS_INT_MASK) mask_q <= data_i & 8'h7F;
            if (take && a0_i && addr_q == usbpc_pkg::OFS_DEV_ADDR) dev_q <= data_i;
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_ctrl_settled;
        ctrl_q == $past(ctrl_q, 3);
    endsequence
    sequence s_start_wr;
        take && a0_i && addr_q == usbpc_pkg::OFS_DMA_CNT_HI && ctrl_q[1] && !dma_busy_o;
    endsequence

    ctrl_bits_a: assert property (s_ctrl_settled |-> usb_enable_o == ctrl_q[0]
        && dma_enable_o == ctrl_q[1] && dma_dir_o == ctrl_q[2] && speed_select_o == ctrl_q[5])
        else $error("ctrl bits");
    standby_level_a: assert property (s_ctrl_settled |-> transceiver_standby_o == ctrl_q[6])
        else $error("standby");
    line_force_a: assert property (s_ctrl_settled |-> line_drive_o ==
        {|ctrl_q[4:3], ctrl_q[4] && ctrl_q[3], ctrl_q[4] && !ctrl_q[3]})
        else $error("line force");
    suspend_join_a: assert property (suspend_o == (transceiver_standby_o && !$past(usb_enable_o)))
        else $error("suspend");
    reset_clear_a: assert property ($rose(nrst_i) |-> line_drive_o == 3'h0 && !usb_enable_o)
        else $error("reset state");
    dma_kick_a: assert property (s_start_wr |-> ##[1:2] dma_start_o)
        else $error("no dma start");
    busy_rise_a: assert property ($rose(dma_busy_o) |-> dma_start_o)
        else $error("busy no start");
    addr_match_a: assert property (token_valid_i && usb_enable_o
        && {1'b0, token_addr_i} == dev_q |=> addr_match_o)
        else $error("no match");
    addr_only_a: assert property (addr_match_o |-> $past(token_valid_i)
        && $past(token_addr_i) == dev_q[6:0] && !dev_q[7])
        else $error("false match");
    irq_block_a: assert property (mask_q == 8'h00 && $past(mask_q) == 8'h00
        |-> !interrupt_request_out_o)
        else $error("masked irq");
    irq_reset_a: assert property (events_i.usb_reset && mask_q[6] |=> interrupt_request_out_o)
        else $error("no irq");
endmodule : usbpc_ctrl_regs_properties

bind usbpc_ctrl_regs usbpc_ctrl_regs_properties i_props (.*);

// ===== testbench/usbpc_host_model.sv
// Host model on the two-phase 8-bit register port.
// Assumes the bench resolves the shared data wire.
`timescale 1ns/10ps
module usbpc_host_model (
    input wire logic clk_i,
    input wire logic [7:0] bus_i,
    output logic cs_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic a0_o,
    output logic [7:0] data_o
);
    initial begin
        {cs_n_o, rd_n_o, wr_n_o} = 3'h7;
        {a0_o, data_o} = 9'h000;
    end

    // One strobe, held two edges; released lines show the inverse
    task automatic cycle(input logic a0, input logic wr, input logic [7:0] d,
                         output logic [7:0] q);
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        a0_o <= a0;
        data_o <= d;
        wr_n_o <= !wr;
        rd_n_o <= wr;
        @(posedge clk_i);
        @(posedge clk_i);
        q = bus_i;
        {cs_n_o, wr_n_o, rd_n_o} <= 3'h7;
        data_o <= ~d;
    endtask : cycle

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        cycle(1'b0, 1'b1, a, q);
        cycle(1'b1, 1'b1, d, q);
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
        cycle(1'b0, 1'b1, a, q);
        cycle(1'b1, 1'b0, 8'h00, q);
    endtask : rd_reg
endmodule : usbpc_host_model

// ===== testbench/tb_usbpc_ctrl_regs.sv
// Bench of the USB peripheral register bank.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
module tb_usbpc_ctrl_regs;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rexp;
        logic [10:0] oexp;
    } usbpc_row_t;

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cs_n, rd_n, wr_n, a0, data_oe, token_valid = 1'b0, dma_byte = 1'b0;
    logic [7:0] host_data, rdata, bus, q;
    logic [5:0] events = 6'h00;
    logic [6:0] token_addr = 7'h00;
    logic standby, suspend, speed, dma_dir, dma_en, usb_en, dma_start, dma_busy, match, irq;
    logic [1:0] ctl2;
    usbpc_pkg::usbpc_line_drive_t line_drive;
    logic [7:0] n_starts = 8'h00, n_match = 8'h00;
    int failures = 0;
    int n_compared = 0;
    int i;
    usbpc_row_t rows [18] = '{
        '{8'h05, 8'h01, 8'h01, 11'h001}, '{8'h05, 8'h02, 8'h02, 11'h002},
        '{8'h05, 8'h04, 8'h04, 11'h004}, '{8'h05, 8'h08, 8'h08, 11'h020},
        '{8'h05, 8'h10, 8'h10, 11'h028}, '{8'h05, 8'h18, 8'h18, 11'h030},
        '{8'h05, 8'h20, 8'h20, 11'h040}, '{8'h05, 8'h40, 8'h40, 11'h180},
        '{8'h05, 8'hFF, 8'h7F, 11'h0F7}, '{8'h05, 8'h00, 8'h00, 11'h000},
        '{8'h06, 8'hFF, 8'h7F, 11'h000}, '{8'h06, 8'h00, 8'h00, 11'h000},
        '{8'h07, 8'hA5, 8'hA5, 11'h000}, '{8'h0F, 8'hFF, 8'hC0, 11'h600},
        '{8'h0F, 8'h00, 8'h00, 11'h000}, '{8'h0E, 8'hFF, 8'h09, 11'h000},
        '{8'h20, 8'hFF, 8'h00, 11'h000}, '{8'h35, 8'h3C, 8'h3C, 11'h000}};

    always #50 clk = ~clk;
    assign bus = data_oe ? rdata : host_data;

    always @(posedge clk) begin
        if (dma_start === 1'b1) n_starts <= n_starts + 8'h01;
        if (match === 1'b1) n_match <= n_match + 8'h01;
    end

    usbpc_host_model i_host (.clk_i(clk), .bus_i(bus), .cs_n_o(cs_n), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .a0_o(a0), .data_o(host_data));

    usbpc_ctrl_regs i_dut (.clk_i(clk), .nrst_i(nrst), .cs_n_i(cs_n), .rd_n_i(rd_n),
        .wr_n_i(wr_n), .a0_i(a0), .data_i(bus), .data_o(rdata), .data_oe_o(data_oe),
        .events_i(events), .frame_number_i(11'h5A3), .buffer_set_i(4'h9),
        .token_valid_i(token_valid), .token_addr_i(token_addr), .dma_byte_i(dma_byte),
        .transceiver_standby_o(standby), .suspend_o(suspend), .speed_select_o(speed),
        .line_drive_o(line_drive), .dma_dir_o(dma_dir), .dma_enable_o(dma_en),
        .usb_enable_o(usb_en), .master_mode_o(ctl2[1]), .polarity_swap_o(ctl2[0]),
        .dma_start_o(dma_start), .dma_busy_o(dma_busy), .addr_match_o(match),
        .interrupt_request_out_o(irq));

    wire [10:0] outs = {ctl2, suspend, standby, speed, line_drive, dma_dir, dma_en, usb_en};

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.wr_reg(a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        i_host.rd_reg(a, q);
    endtask : rd

    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic pulse(input logic [5:0] v);
        @(posedge clk);
        events <= v;
        @(posedge clk);
        events <= 6'h00;
        @(posedge clk);
    endtask : pulse

    task automatic end_of_test;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        check(line_drive, 9'h000);
        rd(8'h05);
        check(q, 8'h00);
        rd(8'h07);
        check(q, 8'h00);
        $display("test reset done");
        // Forced K row is the wake-up signalling of the host
        foreach (rows[k]) begin
            wr(rows[k].addr, rows[k].wdata);
            rd(rows[k].addr);
            check(q, rows[k].rexp);
            check(outs, rows[k].oexp);
        end
        $display("test table done");
        wr(8'h06, 8'h40);
        pulse(6'h10);
        check(irq, 1'b0);
        rd(8'h0D);
        check(q, 8'h20);
        rd(8'h15);
        check(q, 8'h46);
        rd(8'h16);
        check(q, 8'hB0);
        pulse(6'h20);
        check(irq, 1'b1);
        rd(8'h0D);
        check(q, 8'h60);
        wr(8'h06, 8'h00);
        check(irq, 1'b0);
        rd(8'h0D);
        check(q, 8'h60);
        wr(8'h0D, 8'h20);
        rd(8'h0D);
        check(q, 8'h40);
        wr(8'h0D, 8'h7F);
        for (i = 0; i < 4; i++) begin
            wr(8'h06, 8'h01 << i);
            pulse(6'h01 << i);
            check(irq, 1'b1);
            wr(8'h0D, 8'h01 << i);
            check(irq, 1'b0);
        end
        $display("test flags done");
        wr(8'h06, 8'h10);
        wr(8'h05, 8'h02);
        wr(8'h35, 8'h02);
        wr(8'h36, 8'h00);
        @(posedge clk);
        check(n_starts, 8'h01);
        rd(8'h06);
        check(q, 8'h90);
        repeat (2) begin
            @(posedge clk);
            dma_byte <= 1'b1;
            @(posedge clk);
            dma_byte <= 1'b0;
        end
        for (i = 0; i < 20 && dma_busy !== 1'b0; i++) @(posedge clk);
        if (i == 20) begin
            failures++;
            end_of_test();
        end
        repeat (2) @(posedge clk);
        check(irq, 1'b1);
        rd(8'h06);
        check(q, 8'h10);
        $display("test dma done");
        wr(8'h05, 8'h01);
        wr(8'h07, 8'h2A);
        for (i = 0; i < 2; i++) begin
            @(posedge clk);
            token_addr <= 7'h2A + i[6:0];
            token_valid <= 1'b1;
            @(posedge clk);
            token_valid <= 1'b0;
            repeat (2) @(posedge clk);
        end
        check(n_match, 8'h01);
        $display("test address done");
        end_of_test();
    end
endmodule : tb_usbpc_ctrl_regs
